// *** hw/scfg_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - bit 18 gates fixed-range dram attributes
// - bit 19 set: attribute bits accessed normally
// - bit 19 clear: writes ignored, reads zero
// - bit 20 enables lower limit, io ranges
// - bit 21 enables upper memory limit
// - bit 22 forces write-back from 4GB up to the upper memory limit, when bit 21 is set
// - forced write-back needs default type enable
// - ranges and page table override default
// - bit 23 enables memory encryption
// - lock makes encryption enable sticky at one
// - documented bits read and write
module scfg_top (
   input  wire logic        sys_clk,               // core clock, 200 MHz
   input  wire logic        reset_n,               // async reset
   input  wire logic [31:0] msr_addr,              // msr address
   input  wire logic        msr_rd,                // msr read strobe
   input  wire logic        msr_wr,                // msr write strobe
   input  wire logic [63:0] msr_wdata,             // msr write data
   output logic      [63:0] msr_rdata,             // msr read data
   output logic             msr_ack,               // access hit this register
   output logic             msr_fault,             // access to unmapped address
   input  wire logic        mgmt_mode_lock,        // management-mode lock
   input  wire logic [3:0]  fix_sel,               // fixed-range register index
   input  wire logic        fix_rd,                // fixed-range attribute read
   input  wire logic        fix_wr,                // fixed-range attribute write
   input  wire logic [63:0] fix_wdata,             // fixed-range write data
   output logic      [63:0] fix_rdata,             // attribute bits read back
   input  wire logic [3:0]  lk_sel,                // lookup register index
   input  wire logic [2:0]  lk_field,              // lookup field within register
   output logic             lk_read_to_dram,       // effective read attribute
   output logic             lk_write_to_dram,      // effective write attribute
   output logic             lower_limit_enable,    // lower memory limit active
   output logic             var_range_io_enable,   // variable io ranges active
   output logic             upper_limit_enable,    // upper memory limit active
   output logic             mem_encrypt_enable,    // encryption features active
   input  wire logic        default_type_enable,   // default-type register enable
   input  wire logic [7:0]  default_type,          // default memory type
   input  wire logic [51:0] lookup_addr,           // physical address to type
   input  wire logic [51:0] upper_memory_limit,    // upper limit register value
   input  wire logic        range_hit,             // a type range matched
   input  wire logic [7:0]  range_type,            // matched range type
   input  wire logic        page_attr_valid,       // page table gives a type
   input  wire logic [7:0]  page_attr_type,        // page table type
   output logic      [7:0]  resolved_type          // resolved type, one cycle later
);

   // ****************************************************************
   // configuration register
   // ****************************************************************
   logic [63:0] cfg_reg;
   logic [63:0] cfg_next;
   logic [63:0] rdata_reg;
   logic [63:0] rdata_next;
   logic        ack_reg;
   logic        ack_next;
   logic        fault_reg;
   logic        fault_next;
   logic        hit;

   // full 32-bit compare: a partial decode would alias other registers
   assign hit = (msr_addr == scfg_pkg::SYSTEM_CONFIGURATION_ADDR);

   always_comb begin
      cfg_next   = cfg_reg;
      rdata_next = 64'h0;
      ack_next   = (msr_rd || msr_wr) && hit;
      fault_next = (msr_rd || msr_wr) && !hit;
      if (msr_wr && hit) begin
         cfg_next = msr_wdata & scfg_pkg::CFG_WRITE_MASK;
         if (mgmt_mode_lock && cfg_reg[scfg_pkg::ENCRYPT_BIT]) begin
            cfg_next[scfg_pkg::ENCRYPT_BIT] = 1'b1;
         end
      end
      if (msr_rd && hit) begin
         rdata_next = cfg_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg   <= scfg_pkg::CFG_RESET;
         rdata_reg <= 64'h0;
         ack_reg   <= 1'b0;
         fault_reg <= 1'b0;
      end else begin
         cfg_reg   <= cfg_next;
         rdata_reg <= rdata_next;
         ack_reg   <= ack_next;
         fault_reg <= fault_next;
      end
   end

   // answers are registered so the caller always sees them one cycle on
   assign msr_rdata = rdata_reg;
   assign msr_ack   = ack_reg;
   assign msr_fault = fault_reg;

   // ****************************************************************
   // enables
   // ****************************************************************
   // one bit drives both
   assign lower_limit_enable  = cfg_reg[scfg_pkg::VAR_RANGE_IO_BIT];
   assign var_range_io_enable = cfg_reg[scfg_pkg::VAR_RANGE_IO_BIT];
   assign upper_limit_enable  = cfg_reg[scfg_pkg::UPPER_LIMIT_BIT];
   assign mem_encrypt_enable  = cfg_reg[scfg_pkg::ENCRYPT_BIT];

   // ****************************************************************
   // fixed-range read/write-to-dram attribute store
   // ****************************************************************
   // only the two attribute bits per field live here; the type bits belong
   // to the fixed-range registers themselves
   logic [15:0] attr_mem      [scfg_pkg::FIX_REGS];
   logic [15:0] attr_mem_next [scfg_pkg::FIX_REGS];
   logic [15:0] attr_row_next;
   logic        attr_we;
   logic [63:0] fix_rdata_reg;
   logic [63:0] fix_rdata_next;
   logic        fix_ok;
   logic        lk_ok;
   logic [15:0] lk_row;

   // bit of one attribute inside a packed row of field pairs; the read
   // attribute sits just above the write attribute of the same field
   function automatic int attr_pos(input int field, input logic is_rd);
      return (2 * field) + (is_rd ? 1 : 0);
   endfunction

   assign fix_ok = (fix_sel < 4'(scfg_pkg::FIX_REGS));
   assign lk_ok  = (lk_sel < 4'(scfg_pkg::FIX_REGS));
   assign lk_row = lk_ok ? attr_mem[lk_sel] : 16'h0;

   always_comb begin
      attr_row_next  = 16'h0;
      fix_rdata_next = 64'h0;
      attr_we = fix_wr && fix_ok && cfg_reg[scfg_pkg::FIX_ATTR_ACCESS_BIT];
      for (int f = 0; f < scfg_pkg::FIX_FIELDS; f++) begin
         attr_row_next[attr_pos(f, 1'b1)] =
            fix_wdata[scfg_pkg::scfg_lane(f) + scfg_pkg::RD_DRAM_POS];
         attr_row_next[attr_pos(f, 1'b0)] =
            fix_wdata[scfg_pkg::scfg_lane(f) + scfg_pkg::WR_DRAM_POS];
      end
      // only the addressed row takes the new pair; the rest hold
      for (int r = 0; r < scfg_pkg::FIX_REGS; r++) begin
         attr_mem_next[r] = attr_mem[r];
         if (attr_we && (fix_sel == 4'(r))) begin
            attr_mem_next[r] = attr_row_next;
         end
      end
      if (fix_rd && fix_ok && cfg_reg[scfg_pkg::FIX_ATTR_ACCESS_BIT]) begin
         for (int f = 0; f < scfg_pkg::FIX_FIELDS; f++) begin
            fix_rdata_next[scfg_pkg::scfg_lane(f) + scfg_pkg::RD_DRAM_POS] =
               attr_mem[fix_sel][attr_pos(f, 1'b1)];
            fix_rdata_next[scfg_pkg::scfg_lane(f) + scfg_pkg::WR_DRAM_POS] =
               attr_mem[fix_sel][attr_pos(f, 1'b0)];
         end
      end
   end

   // one flop row per register; rows are small, so plain flops beat a
   // memory macro and keep the lookup path free of read latency
   generate
      for (genvar r = 0; r < scfg_pkg::FIX_REGS; r++) begin : g_attr
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               attr_mem[r] <= scfg_pkg::FIX_ATTR_RESET;
            end else begin
               attr_mem[r] <= attr_mem_next[r];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fix_rdata_reg <= 64'h0;
      end else begin
         fix_rdata_reg <= fix_rdata_next;
      end
   end

   assign fix_rdata = fix_rdata_reg;

   assign lk_read_to_dram  = cfg_reg[scfg_pkg::FIX_ATTR_EN_BIT]
                             && lk_row[attr_pos(int'(lk_field), 1'b1)];
   assign lk_write_to_dram = cfg_reg[scfg_pkg::FIX_ATTR_EN_BIT]
                             && lk_row[attr_pos(int'(lk_field), 1'b0)];

   // ****************************************************************
   // default memory type resolution
   // ****************************************************************
   scfg_ctl_if ctl_if ();

   assign ctl_if.upper_limit_enable  = cfg_reg[scfg_pkg::UPPER_LIMIT_BIT];
   assign ctl_if.force_writeback     = cfg_reg[scfg_pkg::FORCE_WB_BIT];
   assign ctl_if.default_type_enable = default_type_enable;
   assign ctl_if.default_type        = default_type;
   assign ctl_if.lookup_addr         = lookup_addr;
   assign ctl_if.upper_memory_limit  = upper_memory_limit;
   assign ctl_if.range_hit           = range_hit;
   assign ctl_if.range_type          = range_type;
   assign ctl_if.page_attr_valid     = page_attr_valid;
   assign ctl_if.page_attr_type      = page_attr_type;

   scfg_mem_type scfg_mem_type_inst (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .ctl     (ctl_if)
   );

   assign resolved_type = ctl_if.resolved_type;

endmodule

// *** hw/scfg_pkg.sv ***
package scfg_pkg;

   // ****************************************************************
   // register address and fields
   // ****************************************************************
   localparam logic [31:0] SYSTEM_CONFIGURATION_ADDR = 32'hc001_0010;
   localparam int          FIX_ATTR_EN_BIT         = 18;
   localparam int          FIX_ATTR_ACCESS_BIT     = 19;
   localparam int          VAR_RANGE_IO_BIT        = 20;
   localparam int          UPPER_LIMIT_BIT         = 21;
   localparam int          FORCE_WB_BIT            = 22;
   localparam int          ENCRYPT_BIT             = 23;
   localparam logic [63:0] CFG_RESET               = 64'h0000_0000_0000_0000;
   localparam logic [63:0] CFG_WRITE_MASK          = 64'h0000_0000_00fc_0000;

   // ****************************************************************
   // fixed-range attribute store
   // ****************************************************************
   localparam int          FIX_REGS                = 11;
   localparam int          FIX_FIELDS              = 8;
   localparam int          FIX_SEL_W               = 4;
   localparam int          FIELD_W                 = 8;
   localparam int          RD_DRAM_POS             = 4;
   localparam int          WR_DRAM_POS             = 3;
   localparam logic [15:0] FIX_ATTR_RESET          = 16'h0000;

   // ****************************************************************
   // memory typing
   // ****************************************************************
   localparam int          PADDR_W                 = 52;
   localparam int          TYPE_W                  = 8;
   localparam logic [51:0] FOUR_GB                 = 52'h0_0001_0000_0000;
   // encoding of the write-back type; plain default, adjust per model
   localparam logic [7:0]  TYPE_WRITEBACK          = 8'h06;
   localparam logic [7:0]  TYPE_RESET              = 8'h00;

   // field lane of attribute pair within a 64-bit fixed-range word
   function automatic int scfg_lane(input int field);
      return field * FIELD_W;
   endfunction

endpackage

// *** hw/scfg_ctl_if.sv ***
`timescale 1ns/1ps
interface scfg_ctl_if;
   logic                                upper_limit_enable;
   logic                                force_writeback;
   logic                                default_type_enable;
   logic [scfg_pkg::TYPE_W-1:0]         default_type;
   logic [scfg_pkg::PADDR_W-1:0]        lookup_addr;
   logic [scfg_pkg::PADDR_W-1:0]        upper_memory_limit;
   logic                                range_hit;
   logic [scfg_pkg::TYPE_W-1:0]         range_type;
   logic                                page_attr_valid;
   logic [scfg_pkg::TYPE_W-1:0]         page_attr_type;
   logic [scfg_pkg::TYPE_W-1:0]         resolved_type;

   modport ctl (
      output upper_limit_enable, force_writeback, default_type_enable, default_type,
      output lookup_addr, upper_memory_limit, range_hit, range_type,
      output page_attr_valid, page_attr_type,
      input  resolved_type
   );
   modport typ (
      input  upper_limit_enable, force_writeback, default_type_enable, default_type,
      input  lookup_addr, upper_memory_limit, range_hit, range_type,
      input  page_attr_valid, page_attr_type,
      output resolved_type
   );
endinterface

// *** hw/scfg_mem_type.sv ***
`timescale 1ns/1ps
module scfg_mem_type (
   input  wire logic sys_clk,         // core clock
   input  wire logic reset_n,         // async reset
   scfg_ctl_if.typ   ctl              // controls and lookup
);

   logic [scfg_pkg::TYPE_W-1:0] type_reg;
   logic [scfg_pkg::TYPE_W-1:0] type_next;
   logic                        in_upper;

   always_comb begin
      // upper region only exists while its limit register is enabled
      in_upper  = ctl.upper_limit_enable
                  && (ctl.lookup_addr >= scfg_pkg::FOUR_GB)
                  && (ctl.lookup_addr < ctl.upper_memory_limit);
      type_next = ctl.default_type;
      if (ctl.default_type_enable && ctl.force_writeback && in_upper) begin
         type_next = scfg_pkg::TYPE_WRITEBACK;
      end
      if (ctl.range_hit) begin
         type_next = ctl.range_type;
      end
      if (ctl.page_attr_valid) begin
         type_next = ctl.page_attr_type;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         type_reg <= scfg_pkg::TYPE_RESET;
      end else begin
         type_reg <= type_next;
      end
   end

   assign ctl.resolved_type = type_reg;

endmodule

// *** testbench/scfg_monitor.sv ***
`timescale 1ns/1ps
module scfg_monitor (
   input wire logic        sys_clk,             // clock
   input wire logic        reset_n,             // async reset
   input wire logic [31:0] msr_addr,            // address
   input wire logic        msr_rd,              // read strobe
   input wire logic        msr_wr,              // write strobe
   input wire logic [63:0] msr_wdata,           // write data
   input wire logic [63:0] msr_rdata,           // read data
   input wire logic        msr_ack,             // hit
   input wire logic        msr_fault,           // miss
   input wire logic        mgmt_mode_lock,      // lock
   input wire logic        lower_limit_enable,  // bit 20
   input wire logic        var_range_io_enable, // bit 20
   input wire logic        upper_limit_enable,  // bit 21
   input wire logic        mem_encrypt_enable,  // bit 23
   input wire logic        range_hit,           // range match
   input wire logic [7:0]  range_type,          // range type
   input wire logic        page_attr_valid,     // page type valid
   input wire logic [7:0]  page_attr_type,      // page type
   input wire logic [7:0]  resolved_type        // result
);
   localparam logic [31:0] ADDR = scfg_pkg::SYSTEM_CONFIGURATION_ADDR;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_hit;
      (msr_rd || msr_wr) && msr_addr == ADDR;
   endsequence
   sequence s_miss;
      (msr_rd || msr_wr) && msr_addr != ADDR;
   endsequence
   sequence s_wr_hit;
      msr_wr && msr_addr == ADDR;
   endsequence
   a_hit_ack: assert property (s_hit |=> msr_ack && !msr_fault)
      else $error("access to config register not acknowledged");
   a_miss_fault: assert property (
      s_miss |=> msr_fault && !msr_ack && msr_rdata == 64'h0)
      else $error("unmapped access not refused");
   a_rdata_mask: assert property (
      msr_ack |-> (msr_rdata & ~scfg_pkg::CFG_WRITE_MASK) == 64'h0)
      else $error("undocumented bit reads nonzero");
   a_lock_sticky: assert property (
      (s_wr_hit ##0 (mgmt_mode_lock && mem_encrypt_enable)) |=> mem_encrypt_enable)
      else $error("locked encryption enable cleared");
   a_encrypt_wr: assert property (
      (s_wr_hit ##0 !(mgmt_mode_lock && mem_encrypt_enable))
      |=> mem_encrypt_enable == $past(msr_wdata[scfg_pkg::ENCRYPT_BIT]))
      else $error("encryption enable not written");
   a_limit_wr: assert property (
      s_wr_hit |=> upper_limit_enable == $past(msr_wdata[scfg_pkg::UPPER_LIMIT_BIT])
      && lower_limit_enable == $past(msr_wdata[scfg_pkg::VAR_RANGE_IO_BIT]))
      else $error("limit enables not written");
   a_io_pair: assert property (var_range_io_enable == lower_limit_enable)
      else $error("io range and lower limit enables differ");
   a_cfg_hold: assert property (!msr_wr |=> $stable({upper_limit_enable, mem_encrypt_enable, lower_limit_enable}))
      else $error("enable changed without a write");
   a_page_first: assert property (
      page_attr_valid |=> resolved_type == $past(page_attr_type))
      else $error("page type not given priority");
   a_range_next: assert property (
      !page_attr_valid && range_hit |=> resolved_type == $past(range_type))
      else $error("range type not given priority");
   a_idle_quiet: assert property (
      !msr_rd && !msr_wr |=> !msr_ack && !msr_fault && msr_rdata == 64'h0)
      else $error("answer without request");
endmodule
bind scfg_top scfg_monitor scfg_monitor_inst (.sys_clk, .reset_n, .msr_addr, .msr_rd, .msr_wr,
   .msr_wdata, .msr_rdata, .msr_ack, .msr_fault, .mgmt_mode_lock, .lower_limit_enable,
   .var_range_io_enable, .upper_limit_enable, .mem_encrypt_enable, .range_hit, .range_type,
   .page_attr_valid, .page_attr_type, .resolved_type);

// *** testbench/scfg_top_tb.sv ***
`timescale 1ns/1ps
module scfg_top_tb;
   localparam logic [31:0] A = scfg_pkg::SYSTEM_CONFIGURATION_ADDR;
   logic        sys_clk, reset_n, msr_rd, msr_wr, msr_ack, msr_fault, mgmt_mode_lock;
   logic        fix_rd, fix_wr, lk_read_to_dram, lk_write_to_dram, lower_limit_enable;
   logic        var_range_io_enable, upper_limit_enable, mem_encrypt_enable;
   logic        default_type_enable, range_hit, page_attr_valid, ak, ft;
   logic [31:0] msr_addr;
   logic [63:0] msr_wdata, msr_rdata, fix_wdata, fix_rdata, rd;
   logic [3:0]  fix_sel, lk_sel;
   logic [2:0]  lk_field;
   logic [7:0]  default_type, range_type, page_attr_type, resolved_type;
   logic [51:0] lookup_addr, upper_memory_limit;
   int          err_count;
   int          checks;
   scfg_top scfg_top_inst (.sys_clk, .reset_n, .msr_addr, .msr_rd, .msr_wr, .msr_wdata,
      .msr_rdata, .msr_ack, .msr_fault, .mgmt_mode_lock, .fix_sel, .fix_rd, .fix_wr,
      .fix_wdata, .fix_rdata, .lk_sel, .lk_field, .lk_read_to_dram, .lk_write_to_dram,
      .lower_limit_enable, .var_range_io_enable, .upper_limit_enable, .mem_encrypt_enable,
      .default_type_enable, .default_type, .lookup_addr, .upper_memory_limit, .range_hit,
      .range_type, .page_attr_valid, .page_attr_type, .resolved_type);
   // ******************************
   // helpers
   // ******************************
   task give_verdict;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // privileged msr access
   // strobe one cycle, sample the answer at the following falling edge
   task msr(input logic w, input logic [31:0] a, input logic [63:0] d);
      @(negedge sys_clk);
      {msr_wr, msr_rd, msr_addr, msr_wdata} = {w, !w, a, d};
      @(negedge sys_clk);
      {rd, ak, ft} = {msr_rdata, msr_ack, msr_fault};
      {msr_wr, msr_rd} = 2'b00;
   endtask
   task cfg(input logic [63:0] d);
      msr(1'b1, A, d);
      chk({62'h0, ak, ft}, 64'h2);
   endtask
   task rdc(input logic [63:0] e);
      msr(1'b0, A, 64'h0);
      chk({62'h0, ak, ft}, 64'h2);
      chk(rd, e);
   endtask
   task en(input logic [3:0] e);
      chk({60'h0, lower_limit_enable, var_range_io_enable, upper_limit_enable,
           mem_encrypt_enable}, {60'h0, e});
   endtask
   task fix(input logic w, input logic [3:0] s, input logic [63:0] d);
      @(negedge sys_clk);
      {fix_wr, fix_rd, fix_sel, fix_wdata} = {w, !w, s, d};
      @(negedge sys_clk);
      rd = fix_rdata;
      {fix_wr, fix_rd} = 2'b00;
   endtask
   task typ(input logic pv, input logic rh, input logic [51:0] ad, input logic [7:0] e);
      @(negedge sys_clk);
      {page_attr_valid, range_hit, lookup_addr} = {pv, rh, ad};
      @(negedge sys_clk);
      chk({56'h0, resolved_type}, {56'h0, e});
   endtask
   // ******************************
   // scenarios
   // ******************************
   task t_regs;
      rdc(64'h0);
      en(4'h0);
      cfg('1);
      en(4'hf);
      rdc(64'h00fc_0000);
      cfg(64'h0010_0000);
      en(4'hc);
      cfg(64'h0020_0000);
      en(4'h2);
      msr(1'b1, A + 32'h1, '1);
      chk({62'h0, ak, ft}, 64'h1);
      rdc(64'h0020_0000);
      $display("t_regs done");
   endtask
   task t_lock;
      cfg(64'h0080_0000);
      mgmt_mode_lock = 1'b1;
      cfg(64'h0);
      rdc(64'h0080_0000);
      mgmt_mode_lock = 1'b0;
      cfg(64'h0);
      rdc(64'h0);
      mgmt_mode_lock = 1'b1;
      cfg(64'h0080_0000);
      en(4'h1);
      mgmt_mode_lock = 1'b0;
      $display("t_lock done");
   endtask
   task t_fix;
      cfg(64'h0);
      fix(1'b1, 4'h0, '1);
      cfg(64'h0008_0000);
      fix(1'b0, 4'h0, 64'h0);
      chk(rd, 64'h0);
      fix(1'b1, 4'h0, '1);
      fix(1'b0, 4'h0, 64'h0);
      chk(rd, 64'h1818_1818_1818_1818);
      fix(1'b1, 4'ha, 64'h10);
      fix(1'b0, 4'ha, 64'h0);
      chk(rd, 64'h10);
      fix(1'b1, 4'hb, '1);
      fix(1'b0, 4'hb, 64'h0);
      chk(rd, 64'h0);
      {lk_sel, lk_field} = {4'h0, 3'h7};
      @(negedge sys_clk);
      chk({62'h0, lk_read_to_dram, lk_write_to_dram}, 64'h0);
      cfg(64'h000c_0000);
      chk({62'h0, lk_read_to_dram, lk_write_to_dram}, 64'h3);
      cfg(64'h0004_0000);
      fix(1'b0, 4'h0, 64'h0);
      chk(rd, 64'h0);
      $display("t_fix done");
   endtask
   task t_type;
      {default_type_enable, default_type, range_type, page_attr_type} = {1'b1, 24'h01_04_05};
      upper_memory_limit = 52'h2_0000_0000;
      cfg(64'h0060_0000);
      typ(1'b0, 1'b0, 52'h1_0000_0000, 8'h06);
      typ(1'b0, 1'b0, 52'h0_ffff_ffff, 8'h01);
      typ(1'b0, 1'b0, 52'h2_0000_0000, 8'h01);
      typ(1'b0, 1'b1, 52'h1_0000_0000, 8'h04);
      typ(1'b1, 1'b1, 52'h1_0000_0000, 8'h05);
      default_type_enable = 1'b0;
      typ(1'b0, 1'b0, 52'h1_0000_0000, 8'h01);
      default_type_enable = 1'b1;
      cfg(64'h0020_0000);
      typ(1'b0, 1'b0, 52'h1_0000_0000, 8'h01);
      $display("t_type done");
   endtask
   // ******************************
   // clock, reset, run
   // ******************************
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // generous bound: the run needs well under 200 cycles
   initial begin
      repeat (2000) @(posedge sys_clk);
      err_count++;
      $display("ERROR %0t run did not finish", $time);
      give_verdict;
   end
   initial begin
      err_count = 0;
      checks = 0;
      reset_n = 1'b0;
      {msr_addr, msr_rd, msr_wr, msr_wdata, mgmt_mode_lock, fix_sel, fix_rd, fix_wr} = '0;
      {fix_wdata, lk_sel, lk_field, default_type_enable, default_type, lookup_addr} = '0;
      {upper_memory_limit, range_hit, range_type, page_attr_valid, page_attr_type} = '0;
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      reset_n = 1'b1;
      t_regs;
      t_lock;
      t_fix;
      t_type;
      give_verdict;
   end
endmodule
